/* design/hspsu_pkg.sv */
// Shared constants and types of the host serial port (UART / SPI slave)
package hspsu_pkg;

    // -----------------------------------------------------------------
    // Port selection
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {HSPSU_UART, HSPSU_SPI, HSPSU_I2C} hspsu_mode_t;

    // -----------------------------------------------------------------
    // FIFOs and idle pattern
    // -----------------------------------------------------------------
    localparam int FIFO_DEPTH = 1024;
    localparam int FIFO_AW = $clog2(FIFO_DEPTH);
    localparam logic [7:0] IDLE_FIRST = 8'ha7;
    localparam logic [7:0] IDLE_SECOND = 8'hb4;
    localparam logic [15:0] IDLE_DEFAULT = {IDLE_FIRST, IDLE_SECOND};
    localparam int RTS_MARGIN = 16;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int UART_DEFAULT_BAUD = 4800;
    localparam int UART_MIN_BAUD = 900;
    localparam int UART_MAX_BAUD = 1_800_000;
    localparam int BAUD_W = $clog2(CLK_HZ / UART_MIN_BAUD + 1);
    localparam int UART_DEFAULT_DIV = CLK_HZ / UART_DEFAULT_BAUD;
    localparam int UART_FRAME_BITS = 10;
    localparam logic [3:0] UART_LAST_BIT = 4'h9;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam logic [2:0] CLEAR_CYCLES = 3'h4;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage : hspsu_pkg

/* design/hspsu_top.sv */
// Host serial port: strap-selected UART or SPI slave on shared pads
`timescale 1ns/1ps

module hspsu_top #(
    parameter int FIFO_AW = hspsu_pkg::FIFO_AW,
    parameter int UART_DEFAULT_DIV = hspsu_pkg::UART_DEFAULT_DIV
) (
    input wire logic i_ref_clk, // System clock
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_rx_pad, // RX / MOSI pad in
    output logic o_rx_pad, // RX pad out (never driven here)
    output logic o_rx_pad_oe, // RX pad enable
    input wire logic i_tx_pad, // TX pad in (unused)
    output logic o_tx_pad, // TX / MISO pad out
    output logic o_tx_pad_oe, // TX pad enable
    input wire logic i_flow_in_sclk_pad, // CTS / SCK pad in, SPI link clock
    output logic o_flow_in_sclk_pad, // Flow-in pad out
    output logic o_flow_in_sclk_pad_oe, // Flow-in pad enable
    input wire logic i_flow_out_csn_pad, // Chip select pad in
    output logic o_flow_out_csn_pad, // RTS pad out
    output logic o_flow_out_csn_pad_oe, // RTS pad enable
    input wire logic [7:0] i_tx_data, // Byte to transmit FIFO
    input wire logic i_tx_valid, // Transmit byte offered
    output logic o_tx_ready, // Transmit FIFO not full
    input wire logic i_tx_fifo_enable, // Pulse: enable transmit FIFO
    output logic o_tx_fifo_enabled, // Transmit FIFO enabled
    output logic [7:0] o_rx_data, // Head of receive FIFO
    output logic o_rx_valid, // Receive FIFO not empty
    input wire logic i_rx_ready, // Consume head byte
    input wire logic i_idle_load, // Pulse: load idle patterns
    input wire logic [15:0] i_tx_idle_pattern, // Transmit idle pair
    input wire logic [15:0] i_rx_idle_pattern, // Receive idle pair
    input wire logic [7:0] i_rx_idle_repeats, // Idle repeats before blocking
    input wire logic [FIFO_AW:0] i_tx_threshold, // Transmit low-level mark
    input wire logic [FIFO_AW:0] i_rx_threshold, // Receive high-level mark
    output logic o_tx_level_irq, // Transmit fill at or below mark
    output logic o_rx_level_irq, // Receive fill at or above mark
    output logic o_sync_error, // Sticky SPI sync error
    input wire logic i_spi_soft_reset, // Pulse: reset SPI logic
    input wire logic [hspsu_pkg::BAUD_W-1:0] i_baud_div, // Clocks per UART bit
    input wire logic i_baud_load, // Pulse: load divisor
    input wire logic i_uart_flow_en, // Use flow pads in UART mode
    output hspsu_pkg::hspsu_mode_t o_port_mode // Selected port type
);
    import hspsu_pkg::*;

    localparam int DEPTH = 1 << FIFO_AW;
    localparam int CW = FIFO_AW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] RTS_LEVEL = CW'(DEPTH - RTS_MARGIN);
    localparam logic [BAUD_W-1:0] DEFAULT_DIV = BAUD_W'(UART_DEFAULT_DIV);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        hspsu_mode_t mode;
        logic strap_done;
        logic [1:0] strap_cnt;
        logic [1:0] cts_s;
        logic [1:0] csn_s;
        logic [1:0] urx_s;
        logic [1:0] mid_s;
        logic [2:0] rxt_s;
        logic [2:0] txt_s;
        logic [CW-1:0] tx_wp;
        logic [CW-1:0] tx_rp;
        logic [CW-1:0] rx_wp;
        logic [CW-1:0] rx_rp;
        logic tx_en;
        logic [7:0] tx_hold;
        logic tx_ph;
        logic rx_ph;
        logic [7:0] rx_rep;
        logic rx_block;
        logic sync_err;
        logic link_clear;
        logic [2:0] clr_cnt;
        logic [15:0] tx_idle_pat;
        logic [15:0] rx_idle_pat;
        logic [BAUD_W-1:0] baud_div;
        logic utx_busy;
        logic [BAUD_W-1:0] utx_cnt;
        logic [3:0] utx_bit;
        logic [UART_FRAME_BITS-1:0] utx_sh;
        logic utx_q;
        logic urx_busy;
        logic [BAUD_W-1:0] urx_cnt;
        logic [3:0] urx_bit;
        logic [7:0] urx_sh;
        logic rts;
        logic tx_irq;
        logic rx_irq;
    } hspsu_sys_t;

    typedef struct packed {
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] rx_byte;
        logic rx_tog;
        logic mid;
    } hspsu_lrx_t;

    typedef struct packed {
        logic [7:0] sh;
        logic miso;
        logic tx_tog;
    } hspsu_ltx_t;

    hspsu_sys_t st, next_st;
    hspsu_lrx_t lr, next_lr;
    hspsu_ltx_t lt, next_lt;
    logic [7:0] tx_mem [DEPTH];
    logic [7:0] rx_mem [DEPTH];
    logic [CW-1:0] tx_cnt, rx_cnt;
    logic tx_push, tx_pop, rx_push, rx_pop, rx_evt, tx_evt, err_set;
    logic [7:0] rx_wbyte, tx_rd;

    function automatic logic [CW-1:0] fifo_count(input logic [CW-1:0] wp, input logic [CW-1:0] rp);
        return wp - rp;
    endfunction : fifo_count

    assign tx_cnt = fifo_count(st.tx_wp, st.tx_rp);
    assign rx_cnt = fifo_count(st.rx_wp, st.rx_rp);
    assign tx_rd = tx_mem[st.tx_rp[FIFO_AW-1:0]];
    assign o_tx_ready = tx_cnt != FULL_COUNT;
    assign tx_push = i_tx_valid && o_tx_ready;
    assign o_rx_valid = rx_cnt != '0;
    assign rx_pop = o_rx_valid && i_rx_ready;
    assign o_rx_data = rx_mem[st.rx_rp[FIFO_AW-1:0]];
    assign rx_evt = st.rxt_s[1] ^ st.rxt_s[2];
    assign tx_evt = st.txt_s[1] ^ st.txt_s[2];
    // Chip select rose while a byte was half shifted
    // Condition lingers until the link is cleared, so it is masked while the clear count runs; else soft reset could never win
    assign err_set = st.strap_done && st.mode == HSPSU_SPI && st.csn_s[1] && st.mid_s[1]
                     && st.clr_cnt == '0 && !st.sync_err;

    // -----------------------------------------------------------------
    // System clock domain
    // -----------------------------------------------------------------
    always_comb begin
        logic keep;
        keep = 1'b0;
        next_st = st;
        rx_push = 1'b0;
        tx_pop = 1'b0;
        rx_wbyte = lr.rx_byte;
        next_st.cts_s = {st.cts_s[0], i_flow_in_sclk_pad};
        next_st.csn_s = {st.csn_s[0], i_flow_out_csn_pad};
        next_st.urx_s = {st.urx_s[0], i_rx_pad};
        next_st.mid_s = {st.mid_s[0], lr.mid};
        next_st.rxt_s = {st.rxt_s[1:0], lr.rx_tog};
        next_st.txt_s = {st.txt_s[1:0], lt.tx_tog};
        if (!st.strap_done) begin
            // Sync chains must settle before the straps are trusted
            if (st.strap_cnt == STRAP_SETTLE) begin
                next_st.strap_done = 1'b1;
                next_st.mode = st.cts_s[1] ? HSPSU_UART : (!st.csn_s[1] ? HSPSU_I2C : HSPSU_SPI);
            end else begin
                next_st.strap_cnt = st.strap_cnt + 2'h1;
            end
        end
        if (i_idle_load) begin
            next_st.tx_idle_pat = i_tx_idle_pattern;
            next_st.rx_idle_pat = i_rx_idle_pattern;
        end
        if (i_baud_load) begin
            next_st.baud_div = i_baud_div;
        end
        // SPI transmit: next byte is fetched once the link took the last one
        if (st.mode == HSPSU_SPI && tx_evt) begin
            if (st.tx_en && tx_cnt != '0) begin
                tx_pop = 1'b1;
                next_st.tx_hold = tx_rd;
                next_st.tx_ph = 1'b0;
                if (tx_cnt == CW'(1) && !tx_push) begin
                    next_st.tx_en = 1'b0;
                end
            end else begin
                next_st.tx_en = 1'b0;
                next_st.tx_hold = st.tx_ph ? st.tx_idle_pat[7:0] : st.tx_idle_pat[15:8];
                next_st.tx_ph = !st.tx_ph;
            end
        end
        // UART transmit, LSB first framing with start and stop bit
        if (st.mode == HSPSU_UART) begin
            if (!st.utx_busy) begin
                if (tx_cnt != '0 && (!i_uart_flow_en || !st.cts_s[1])) begin
                    tx_pop = 1'b1;
                    next_st.utx_busy = 1'b1;
                    next_st.utx_sh = {1'b1, tx_rd, 1'b0};
                    next_st.utx_cnt = st.baud_div - BAUD_W'(1);
                    next_st.utx_bit = '0;
                end
            end else if (st.utx_cnt != '0) begin
                next_st.utx_cnt = st.utx_cnt - BAUD_W'(1);
            end else begin
                next_st.utx_cnt = st.baud_div - BAUD_W'(1);
                next_st.utx_sh = {1'b1, st.utx_sh[UART_FRAME_BITS-1:1]};
                if (st.utx_bit == UART_LAST_BIT) begin
                    next_st.utx_busy = 1'b0;
                end else begin
                    next_st.utx_bit = st.utx_bit + 4'h1;
                end
            end
        end
        next_st.utx_q = !next_st.utx_busy || next_st.utx_sh[0];
        if (tx_pop) begin
            next_st.tx_rp = st.tx_rp + CW'(1);
        end
        if (tx_push) begin
            next_st.tx_wp = st.tx_wp + CW'(1);
        end
        // SPI receive with idle-run filter
        if (st.mode == HSPSU_SPI && rx_evt) begin
            if (lr.rx_byte == st.rx_idle_pat[15:8]) begin
                next_st.rx_ph = 1'b1;
                keep = !st.rx_block;
            end else if (st.rx_ph && lr.rx_byte == st.rx_idle_pat[7:0]) begin
                next_st.rx_ph = 1'b0;
                keep = !st.rx_block;
                if (st.rx_rep != i_rx_idle_repeats) begin
                    next_st.rx_rep = st.rx_rep + 8'h1;
                end
                if (next_st.rx_rep == i_rx_idle_repeats && i_rx_idle_repeats != '0) begin
                    next_st.rx_block = 1'b1;
                end
            end else begin
                next_st.rx_ph = 1'b0;
                next_st.rx_rep = '0;
                next_st.rx_block = 1'b0;
                keep = 1'b1;
            end
            rx_push = keep && rx_cnt != FULL_COUNT;
        end
        // UART receive: sample mid-bit, stop bit must be high
        if (st.mode == HSPSU_UART) begin
            if (!st.urx_busy) begin
                if (!st.urx_s[1]) begin
                    next_st.urx_busy = 1'b1;
                    next_st.urx_cnt = st.baud_div >> 1;
                    next_st.urx_bit = '0;
                end
            end else if (st.urx_cnt != '0) begin
                next_st.urx_cnt = st.urx_cnt - BAUD_W'(1);
            end else begin
                next_st.urx_cnt = st.baud_div - BAUD_W'(1);
                next_st.urx_bit = st.urx_bit + 4'h1;
                if (st.urx_bit == UART_LAST_BIT) begin
                    next_st.urx_busy = 1'b0;
                    rx_wbyte = st.urx_sh;
                    rx_push = st.urx_s[1] && rx_cnt != FULL_COUNT;
                end else if (st.urx_bit != '0) begin
                    next_st.urx_sh = {st.urx_s[1], st.urx_sh[7:1]};
                end else if (st.urx_s[1]) begin
                    next_st.urx_busy = 1'b0;
                end
            end
        end
        if (rx_push) begin
            next_st.rx_wp = st.rx_wp + CW'(1);
        end
        if (rx_pop) begin
            next_st.rx_rp = st.rx_rp + CW'(1);
        end
        next_st.rts = rx_cnt >= RTS_LEVEL;
        next_st.tx_irq = tx_cnt <= i_tx_threshold;
        next_st.rx_irq = rx_cnt >= i_rx_threshold;
        if (i_spi_soft_reset) begin
            next_st.clr_cnt = CLEAR_CYCLES;
            next_st.tx_wp = '0;
            next_st.tx_rp = '0;
            next_st.rx_wp = '0;
            next_st.rx_rp = '0;
            next_st.tx_en = 1'b0;
            next_st.tx_hold = st.tx_idle_pat[15:8];
            next_st.tx_ph = 1'b1;
            next_st.rx_ph = 1'b0;
            next_st.rx_rep = '0;
            next_st.rx_block = 1'b0;
            next_st.sync_err = 1'b0;
        end else if (st.clr_cnt != '0) begin
            next_st.clr_cnt = st.clr_cnt - 3'h1;
        end
        // Software enable and error set both win over a same-cycle clear
        if (i_tx_fifo_enable) begin
            next_st.tx_en = 1'b1;
        end
        if (err_set) begin
            next_st.sync_err = 1'b1;
        end
        next_st.link_clear = !next_st.strap_done || next_st.mode != HSPSU_SPI || next_st.clr_cnt != '0;
        if (st.link_clear) begin
            next_st.rxt_s = '0;
            next_st.txt_s = '0;
        end
        if (!i_reset_n) begin
            next_st = '0;
            next_st.tx_hold = IDLE_FIRST;
            next_st.tx_ph = 1'b1;
            next_st.tx_idle_pat = IDLE_DEFAULT;
            next_st.rx_idle_pat = IDLE_DEFAULT;
            next_st.baud_div = DEFAULT_DIV;
            next_st.utx_q = 1'b1;
            next_st.link_clear = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end

    always_ff @(posedge i_ref_clk) begin
        if (tx_push) begin
            tx_mem[st.tx_wp[FIFO_AW-1:0]] <= i_tx_data;
        end
        if (rx_push) begin
            rx_mem[st.rx_wp[FIFO_AW-1:0]] <= rx_wbyte;
        end
    end

    // -----------------------------------------------------------------
    // SCK domain: stopped between frames, so it is cleared from the
    // system side; the mid-byte flag survives chip select for the error
    // -----------------------------------------------------------------
    always_comb begin
        next_lr = lr;
        next_lr.bitcnt = lr.bitcnt + 3'h1;
        next_lr.sh = {lr.sh[6:0], i_rx_pad};
        next_lr.mid = next_lr.bitcnt != '0;
        if (lr.bitcnt == SPI_LAST_BIT) begin
            next_lr.rx_byte = {lr.sh[6:0], i_rx_pad};
            next_lr.rx_tog = !lr.rx_tog;
        end
    end

    always_ff @(negedge i_flow_in_sclk_pad or posedge st.link_clear) begin
        if (st.link_clear) begin
            lr <= '0;
        end else begin
            lr <= next_lr;
        end
    end

    // tx_hold only changes after the taken toggle crosses, well inside one byte
    always_comb begin
        next_lt = lt;
        if (lr.bitcnt == '0) begin
            next_lt.miso = st.tx_hold[7];
            next_lt.sh = {st.tx_hold[6:0], 1'b0};
            next_lt.tx_tog = !lt.tx_tog;
        end else begin
            next_lt.miso = lt.sh[7];
            next_lt.sh = {lt.sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_flow_in_sclk_pad or posedge st.link_clear) begin
        if (st.link_clear) begin
            lt <= '0;
        end else begin
            lt <= next_lt;
        end
    end

    // -----------------------------------------------------------------
    // Pads and status
    // -----------------------------------------------------------------
    // I2C is recognised but not served here, so its pads stay released
    assign o_tx_pad = (st.mode == HSPSU_SPI) ? lt.miso : st.utx_q;
    assign o_tx_pad_oe = st.strap_done && (st.mode == HSPSU_UART
                         || (st.mode == HSPSU_SPI && !st.csn_s[1]));
    assign o_flow_out_csn_pad = st.rts;
    assign o_flow_out_csn_pad_oe = st.strap_done && st.mode == HSPSU_UART && i_uart_flow_en;
    assign o_rx_pad = 1'b0;
    assign o_rx_pad_oe = 1'b0;
    assign o_flow_in_sclk_pad = 1'b0;
    assign o_flow_in_sclk_pad_oe = 1'b0;
    assign o_tx_fifo_enabled = st.tx_en;
    assign o_tx_level_irq = st.tx_irq;
    assign o_rx_level_irq = st.rx_irq;
    assign o_sync_error = st.sync_err;
    assign o_port_mode = st.mode;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_last_pop;
        st.mode == HSPSU_SPI && tx_evt && st.tx_en && tx_cnt == CW'(1) && !tx_push;
    endsequence
    sequence s_no_rescue;
        !i_tx_fifo_enable && !i_spi_soft_reset;
    endsequence
    sequence s_blocked_idle;
        st.mode == HSPSU_SPI && rx_evt && st.rx_block && lr.rx_byte == st.rx_idle_pat[15:8];
    endsequence

    property p_quiet;
        !st.strap_done |-> !(o_tx_pad_oe || o_rx_pad_oe || o_flow_out_csn_pad_oe || o_flow_in_sclk_pad_oe);
    endproperty
    a_quiet: assert property (p_quiet) else $error("pad driven before port type known");
    property p_i2c_released;
        st.mode == HSPSU_I2C |-> !(o_tx_pad_oe || o_flow_out_csn_pad_oe);
    endproperty
    a_i2c_released: assert property (p_i2c_released) else $error("unselected port drives pad");
    property p_strap;
        $rose(st.strap_done) |-> st.mode == ($past(st.cts_s[1]) ? HSPSU_UART
            : (!$past(st.csn_s[1]) ? HSPSU_I2C : HSPSU_SPI));
    endproperty
    a_strap: assert property (p_strap) else $error("port type does not match straps");
    property p_uart_default;
        $rose(i_reset_n) |-> st.baud_div == DEFAULT_DIV && st.tx_idle_pat == IDLE_DEFAULT
            && st.rx_idle_pat == IDLE_DEFAULT;
    endproperty
    a_uart_default: assert property (p_uart_default) else $error("wrong defaults after reset");
    property p_baud_load;
        i_baud_load |=> st.baud_div == $past(i_baud_div);
    endproperty
    a_baud_load: assert property (p_baud_load) else $error("baud divisor not loaded");
    property p_miso_select;
        st.mode == HSPSU_SPI && st.csn_s[1] |-> !o_tx_pad_oe;
    endproperty
    a_miso_select: assert property (p_miso_select) else $error("MISO driven while deselected");
    property p_fifo_bound;
        tx_cnt <= FULL_COUNT && rx_cnt <= FULL_COUNT;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("FIFO count out of range");
    property p_tx_self_disable;
        s_last_pop ##0 s_no_rescue |=> !st.tx_en ##1 (!st.tx_en || $past(i_tx_fifo_enable));
    endproperty
    a_tx_self_disable: assert property (p_tx_self_disable) else $error("empty FIFO stayed enabled");
    property p_idle_fill;
        st.mode == HSPSU_SPI && tx_evt && !st.tx_en && !i_spi_soft_reset
            |=> st.tx_hold == ($past(st.tx_ph) ? $past(st.tx_idle_pat[7:0]) : $past(st.tx_idle_pat[15:8]));
    endproperty
    a_idle_fill: assert property (p_idle_fill) else $error("idle byte not sent");
    property p_rx_blocked;
        s_blocked_idle ##0 !i_spi_soft_reset |=> $stable(st.rx_wp);
    endproperty
    a_rx_blocked: assert property (p_rx_blocked) else $error("idle byte stored while blocked");
    property p_level_irq;
        1'b1 |=> st.rx_irq == ($past(rx_cnt) >= $past(i_rx_threshold))
            && st.tx_irq == ($past(tx_cnt) <= $past(i_tx_threshold));
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level flag wrong");
    property p_sync_err;
        err_set |=> st.sync_err ##1 (st.sync_err || $past(i_spi_soft_reset));
    endproperty
    a_sync_err: assert property (p_sync_err) else $error("sync error not held");
    property p_byte_end;
        @(negedge i_flow_in_sclk_pad) disable iff (st.link_clear)
            lr.bitcnt == SPI_LAST_BIT |=> lr.bitcnt == '0 && $changed(lr.rx_tog);
    endproperty
    a_byte_end: assert property (p_byte_end) else $error("byte boundary missed");

endmodule : hspsu_top

/* test/hspsu_spi_master.sv */
// SPI master model standing in for the host processor
`timescale 1ns/1ps
module hspsu_spi_master (
    input wire logic i_miso, // Slave data line
    input wire logic i_miso_oe, // Slave drives data line
    output logic o_sclk = 1'b0, // Serial clock, idles low
    output logic o_mosi = 1'b1, // Master data out
    output logic o_csn = 1'b1 // Chip select, active low
);
    logic tick = 1'b0;
    logic last = 1'b0;
    initial forever #7.5 tick = ~tick;
    task automatic wt(input int n);
        repeat (n) @(posedge tick);
    endtask : wt
    task automatic sel(input logic v);
        wt(5);
        o_csn = v;
        wt(5);
    endtask : sel
    // Half period 75 ns keeps SCK under 6.8 MHz
    task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int b = 7; b > 7 - n; b--) begin
            o_sclk = 1'b1;
            o_mosi = d[b];
            wt(5);
            q[b] = i_miso_oe ? i_miso : ~last;
            last = q[b];
            o_sclk = 1'b0;
            wt(5);
        end
    endtask : xfer
endmodule : hspsu_spi_master

/* test/hspsu_top_tb_top.sv */
// Bench: SPI mode of the host serial port against the master model
`timescale 1ns/1ps
module hspsu_top_tb_top;
    import hspsu_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sck, mosi, csn, miso, moe, rx_oe, rts_oe, ten, rx_v, irq, serr;
    logic [7:0] tx_d = 8'h00;
    logic [7:0] rx_d, q;
    logic tx_v = 1'b0, go = 1'b0, rdy = 1'b0, srst = 1'b0;
    logic ld = 1'b0, txi, trdy;
    logic [15:0] tpat = IDLE_DEFAULT, rpat = IDLE_DEFAULT;
    logic [7:0] rep = 8'h00;
    logic [4:0] tthr = 5'h00, rthr = 5'h02;
    hspsu_mode_t mode;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    hspsu_spi_master m (.i_miso(miso), .i_miso_oe(moe), .o_sclk(sck), .o_mosi(mosi), .o_csn(csn));
    hspsu_top #(.FIFO_AW(4), .UART_DEFAULT_DIV(16)) i_hspsu_top (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_rx_pad(mosi), .o_rx_pad(), .o_rx_pad_oe(rx_oe), .i_tx_pad(1'b0), .o_tx_pad(miso), .o_tx_pad_oe(moe),
        .i_flow_in_sclk_pad(sck), .o_flow_in_sclk_pad(), .o_flow_in_sclk_pad_oe(), .i_flow_out_csn_pad(csn),
        .o_flow_out_csn_pad(), .o_flow_out_csn_pad_oe(rts_oe), .i_tx_data(tx_d), .i_tx_valid(tx_v),
        .o_tx_ready(trdy), .i_tx_fifo_enable(go), .o_tx_fifo_enabled(ten), .o_rx_data(rx_d), .o_rx_valid(rx_v),
        .i_rx_ready(rdy), .i_idle_load(ld), .i_tx_idle_pattern(tpat), .i_rx_idle_pattern(rpat),
        .i_rx_idle_repeats(rep), .i_tx_threshold(tthr), .i_rx_threshold(rthr), .o_tx_level_irq(txi),
        .o_rx_level_irq(irq), .o_sync_error(serr), .i_spi_soft_reset(srst), .i_baud_div(BAUD_W'(16)),
        .i_baud_load(1'b0), .i_uart_flow_en(1'b0), .o_port_mode(mode));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic t_idle();
        m.sel(1'b0);
        m.xfer(8'h3c, 8, q);
        check(q, IDLE_FIRST);
        m.xfer(8'h5a, 8, q);
        check(q, IDLE_SECOND);
        m.sel(1'b1);
        tk(10);
        #1 check(irq, 1'b1);
        for (int i = 0; i < 2; i++) begin
            #1 check(rx_d, i ? 8'h5a : 8'h3c);
            tk(1);
            rdy <= 1'b1;
            tk(1);
            rdy <= 1'b0;
        end
        #1 check(rx_v, 1'b0);
    endtask : t_idle
    task automatic t_data();
        tk(1);
        tx_d <= 8'h5c;
        tx_v <= 1'b1;
        tk(1);
        tx_v <= 1'b0;
        go <= 1'b1;
        tk(1);
        go <= 1'b0;
        #1 check(ten, 1'b1);
        check(txi, 1'b0);
        check(trdy, 1'b1);
        m.sel(1'b0);
        // Hold byte was fetched while disabled, so idle comes first
        m.xfer(IDLE_FIRST, 8, q);
        check(q, IDLE_FIRST);
        m.xfer(IDLE_SECOND, 8, q);
        check(q, 8'h5c);
        m.sel(1'b1);
        tk(10);
        #1 check(ten, 1'b0);
        check(txi, 1'b1);
    endtask : t_data
    task automatic t_sync();
        m.sel(1'b0);
        m.xfer(8'hff, 3, q);
        m.sel(1'b1);
        tk(10);
        #1 check(serr, 1'b1);
        tk(1);
        tx_v <= 1'b1;
        tk(16);
        tx_v <= 1'b0;
        #1 check(trdy, 1'b0);
        tk(1);
        srst <= 1'b1;
        tk(1);
        srst <= 1'b0;
        tk(8);
        #1 check(serr, 1'b0);
        check(rx_v, 1'b0);
        check(trdy, 1'b1);
    endtask : t_sync
    task automatic t_block();
        tk(1);
        tpat <= 16'h1e2d;
        rpat <= 16'h4b69;
        rep <= 8'h01;
        rthr <= 5'h03;
        ld <= 1'b1;
        tk(1);
        ld <= 1'b0;
        srst <= 1'b1;
        tk(1);
        srst <= 1'b0;
        tk(8);
        m.sel(1'b0);
        for (int i = 0; i < 5; i++) begin
            m.xfer(i == 4 ? 8'h3c : (i % 2 ? 8'h69 : 8'h4b), 8, q);
            check(q, i % 2 ? 8'h2d : 8'h1e);
        end
        m.sel(1'b1);
        tk(10);
        #1 check(irq, 1'b1);
        for (int i = 0; i < 3; i++) begin
            #1 check(rx_d, i == 2 ? 8'h3c : (i ? 8'h69 : 8'h4b));
            tk(1);
            rdy <= 1'b1;
            tk(1);
            rdy <= 1'b0;
        end
        #1 check(rx_v, 1'b0);
    endtask : t_block
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        tk(1);
        #1 check(moe | rx_oe | rts_oe, 1'b0);
        tk(1);
        rst_n <= 1'b1;
        tk(8);
        #1 check(mode, HSPSU_SPI);
        check(moe, 1'b0);
        t_idle();
        t_data();
        t_sync();
        t_block();
        end_of_test();
    end
endmodule : hspsu_top_tb_top
